//--- ref_fmt_consts.vh
// Constants for the reference format and genlock status registers.
// Included by the register bank and its serial port; definitions only.
`ifndef REF_FMT_CONSTS_VH
`define REF_FMT_CONSTS_VH

// Register addresses (12-bit serial address space)
`define ADDR_INPUT_FORMAT_SELECT    12'h00f
`define ADDR_AMBIGUOUS_CHOICE       12'h010
`define ADDR_GENLOCK_MASK_0         12'h011
`define ADDR_GENLOCK_MASK_1         12'h012
`define ADDR_GENLOCK_MASK_2         12'h013
`define ADDR_GENLOCK_MASK_3         12'h014
`define ADDR_LOCK_STATUS_FLAGS      12'h015
`define ADDR_GENLOCK_CONTROL        12'h016

// input_format_select fields
`define FORCE_BIT                   12
`define FORCED_HI                   11
`define FORCED_LO                   6
`define DETECTED_HI                 5
`define DETECTED_LO                 0

// ambiguous_format_choice field
`define AMBIG_HI                    10

// Valid detected codes
`define CODE_MIN                    6'h01
`define CODE_MAX                    6'h36

// lock_status_flags bits
`define ST_REF_LOCK                 5
`define ST_F_LOCK                   4
`define ST_V_LOCK                   3
`define ST_H_LOCK                   2
`define ST_CLK_LOCK                 1
`define ST_REF_PRESENT              0

// genlock control mask bits
`define CTL_F_MASK                  4
`define CTL_V_MASK                  3
`define CTL_H_MASK                  2

// Reset values
`define RST_WORD                    16'h0000

// Serial frame: command word then data word, 16 bits each
`define SER_WORD_BITS               5'd16
`define SER_CMD_READ                15

`endif

//--- serial_host_port.v
// Serial host interface slave: 16-bit command, 16-bit data, MSB first.
// Assumes serial clock well below a quarter of clk_sys_i; pins are async.
`timescale 1ns/1ps
`include "ref_fmt_consts.vh"

module serial_host_port (
    // System
    input  wire        clk_sys_i,
    input  wire        rst_i,
    // Pins
    input  wire        sclk_i,
    input  wire        cs_n_i,
    input  wire        sdin_i,
    output reg         sdout_o,
    output reg         sdout_oe_o,
    // Register side
    output reg         wr_stb_o,
    output reg         rd_stb_o,
    output reg  [11:0] addr_o,
    output reg  [15:0] wdata_o,
    input  wire [15:0] rdata_i
);

    reg  [2:0]  sclk_s;
    reg  [1:0]  cs_s;
    reg  [1:0]  sdin_s;
    reg  [5:0]  bit_cnt;
    reg  [15:0] shift_in;
    reg  [15:0] shift_out;
    reg         is_read;
    reg         load_pend;

    wire sclk_rise = sclk_s[1] & ~sclk_s[2];
    wire sclk_fall = ~sclk_s[1] & sclk_s[2];
    wire selected  = ~cs_s[1];
    wire [15:0] next_shift_in = {shift_in[14:0], sdin_s[1]};

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_s     <= 3'h0;
            cs_s       <= 2'h3;
            sdin_s     <= 2'h0;
            bit_cnt    <= 6'h00;
            shift_in   <= 16'h0000;
            shift_out  <= 16'h0000;
            is_read    <= 1'b0;
            load_pend  <= 1'b0;
            sdout_o    <= 1'b0;
            sdout_oe_o <= 1'b0;
            wr_stb_o   <= 1'b0;
            rd_stb_o   <= 1'b0;
            addr_o     <= 12'h000;
            wdata_o    <= 16'h0000;
        end else begin
            sclk_s   <= {sclk_s[1:0], sclk_i};
            cs_s     <= {cs_s[0], cs_n_i};
            sdin_s   <= {sdin_s[0], sdin_i};
            wr_stb_o <= 1'b0;
            rd_stb_o <= 1'b0;
            // Read data is captured one cycle after the strobe
            load_pend <= rd_stb_o;
            if (load_pend) begin
                shift_out <= rdata_i;
            end
            if (!selected) begin
                bit_cnt    <= 6'h00;
                is_read    <= 1'b0;
                sdout_oe_o <= 1'b0;
            end else if (sclk_rise) begin
                shift_in <= next_shift_in;
                if (bit_cnt != 6'h3f) begin
                    bit_cnt <= bit_cnt + 6'h01;
                end
                if (bit_cnt == {1'b0, `SER_WORD_BITS} - 6'h01) begin
                    addr_o   <= next_shift_in[11:0];
                    is_read  <= next_shift_in[`SER_CMD_READ];
                    rd_stb_o <= next_shift_in[`SER_CMD_READ];
                end
                if (bit_cnt == {`SER_WORD_BITS, 1'b0} - 6'h01 && !is_read) begin
                    wdata_o  <= next_shift_in;
                    wr_stb_o <= 1'b1;
                end
            end else if (sclk_fall && is_read && bit_cnt >= {1'b0, `SER_WORD_BITS}) begin
                // Data bits leave on falling edges, host samples on rising
                sdout_oe_o <= 1'b1;
                sdout_o    <= shift_out[15];
                shift_out  <= {shift_out[14:0], 1'b0};
            end
        end
    end

endmodule // serial_host_port

//--- ref_format_genlock_status_regs.v
// Reference format select and genlock status register bank.
// Assumes lock and detector inputs are synchronous to clk_sys_i.
//
// Contract
// - Force bit makes forced code the input standard
// - Forcing selects bits 11-6, ignores detected field
// - Detector writes recognised code into bits 5-0
// - Detected reads zero unless recognised, 1..54
// - Ambiguous choice field steers detector disambiguation
// - Mask bit n blocks genlock to code n
// - Mask spread over four 16-bit registers, low first
// - Overall lock needs bits 4-2 set or masked, bit 1 set
// - Lock-lost pin is inverse of overall lock
// - F lock follows V lock without field sync
// - V and H lock flags follow their genlock
// - Clock lock needs both video and audio PLLs
// - Reference present flag; reference-lost pin inverted
// - Control register holds F, V, H lock masks
// - All registers individually addressable over serial port
`timescale 1ns/1ps
`include "ref_fmt_consts.vh"

module ref_format_genlock_status_regs (
    // System
    input  wire        clk_sys_i,
    input  wire        rst_i,
    // Serial host interface pins
    input  wire        sclk_i,
    input  wire        cs_n_i,
    input  wire        sdin_i,
    output wire        sdout_o,
    output wire        sdout_oe_o,
    // Format detector
    input  wire        det_valid_i,
    input  wire [5:0]  det_code_i,
    input  wire        ref_valid_i,
    input  wire        field_sync_seen_i,
    // Genlock engine lock indications
    input  wire        h_locked_i,
    input  wire        v_locked_i,
    input  wire        f_locked_i,
    input  wire        video_pll_locked_i,
    input  wire        audio_pll_locked_i,
    // To detector and genlock engine
    output reg  [5:0]  video_format_code_o,
    output reg  [10:0] ambiguous_choice_o,
    output reg         genlock_permit_o,
    // Status pins
    output reg         lock_lost_o,
    output reg         ref_lost_o
);

    // Serial port side
    wire        wr_stb;
    wire        rd_stb;
    wire [11:0] addr;
    wire [15:0] wdata;
    reg  [15:0] rdata;

    // Host registers
    reg         force_format;
    reg  [5:0]  forced_code;
    reg  [5:0]  detected_code;
    reg  [10:0] ambiguous_choice;
    reg  [63:0] genlock_mask;
    reg  [2:0]  lock_mask;

    // Status flags
    reg  [5:0]  status_flags;
    reg  [5:0]  next_status;
    reg  [5:0]  next_detected;
    reg  [5:0]  next_format;
    reg         f_eff;
    reg         clk_lock;
    reg         ref_lock;

    serial_host_port u_port (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .sclk_i     (sclk_i),
        .cs_n_i     (cs_n_i),
        .sdin_i     (sdin_i),
        .sdout_o    (sdout_o),
        .sdout_oe_o (sdout_oe_o),
        .wr_stb_o   (wr_stb),
        .rd_stb_o   (rd_stb),
        .addr_o     (addr),
        .wdata_o    (wdata),
        .rdata_i    (rdata)
    );

    // True when a code is one the detector may report
    function code_ok;
        input [5:0] code;
        begin
            code_ok = (code >= `CODE_MIN) && (code <= `CODE_MAX);
        end
    endfunction

    // Select one 16-bit slice of the mask
    function [15:0] mask_slice;
        input [63:0] mask;
        input [1:0]  idx;
        begin
            case (idx)
                2'h0:    mask_slice = mask[15:0];
                2'h1:    mask_slice = mask[31:16];
                2'h2:    mask_slice = mask[47:32];
                default: mask_slice = mask[63:48];
            endcase
        end
    endfunction

    // Detector result, cleared when nothing usable is applied
    always @* begin
        if (ref_valid_i && det_valid_i && code_ok(det_code_i)) begin
            next_detected = det_code_i;
        end else begin
            next_detected = 6'h00;
        end
    end

    // Effective input standard
    always @* begin
        if (force_format) begin
            next_format = forced_code;
        end else begin
            next_format = next_detected;
        end
    end

    // Lock flag formation
    always @* begin
        if (field_sync_seen_i) begin
            f_eff = f_locked_i;
        end else begin
            f_eff = v_locked_i;
        end
        clk_lock = video_pll_locked_i & audio_pll_locked_i;
        ref_lock = (f_eff | lock_mask[2])
                 & (v_locked_i | lock_mask[1])
                 & (h_locked_i | lock_mask[0])
                 & clk_lock;
        next_status = 6'h00;
        next_status[`ST_REF_LOCK]    = ref_lock;
        next_status[`ST_F_LOCK]      = f_eff;
        next_status[`ST_V_LOCK]      = v_locked_i;
        next_status[`ST_H_LOCK]      = h_locked_i;
        next_status[`ST_CLK_LOCK]    = clk_lock;
        next_status[`ST_REF_PRESENT] = ref_valid_i;
    end

    // Status and outputs, refreshed every cycle; pins share the flag's edge
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            status_flags        <= 6'h00;
            detected_code       <= 6'h00;
            video_format_code_o <= 6'h00;
            ambiguous_choice_o  <= 11'h000;
            genlock_permit_o    <= 1'b0;
            lock_lost_o         <= 1'b1;
            ref_lost_o          <= 1'b1;
        end else begin
            status_flags        <= next_status;
            detected_code       <= next_detected;
            video_format_code_o <= next_format;
            ambiguous_choice_o  <= ambiguous_choice;
            // Code zero means no standard, so it never permits genlock
            genlock_permit_o    <= (next_format != 6'h00)
                                 & ~genlock_mask[next_format];
            lock_lost_o         <= ~next_status[`ST_REF_LOCK];
            ref_lost_o          <= ~next_status[`ST_REF_PRESENT];
        end
    end

    // Host writes; reserved bits are dropped whatever the host sends
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            force_format     <= 1'b0;
            forced_code      <= 6'h00;
            ambiguous_choice <= 11'h000;
            genlock_mask     <= {4{`RST_WORD}};
            lock_mask        <= 3'h0;
        end else if (wr_stb) begin
            case (addr)
                `ADDR_INPUT_FORMAT_SELECT: begin
                    force_format <= wdata[`FORCE_BIT];
                    forced_code  <= wdata[`FORCED_HI:`FORCED_LO];
                end
                `ADDR_AMBIGUOUS_CHOICE: begin
                    ambiguous_choice <= wdata[`AMBIG_HI:0];
                end
                `ADDR_GENLOCK_MASK_0: begin
                    genlock_mask[15:0] <= wdata;
                end
                `ADDR_GENLOCK_MASK_1: begin
                    genlock_mask[31:16] <= wdata;
                end
                `ADDR_GENLOCK_MASK_2: begin
                    genlock_mask[47:32] <= wdata;
                end
                `ADDR_GENLOCK_MASK_3: begin
                    genlock_mask[63:48] <= wdata;
                end
                `ADDR_GENLOCK_CONTROL: begin
                    lock_mask <= wdata[`CTL_F_MASK:`CTL_H_MASK];
                end
                default: begin
                    // Status and unmapped addresses ignore writes
                end
            endcase
        end
    end

    // Read mux; unmapped addresses return zero
    always @* begin
        rdata = 16'h0000;
        case (addr)
            `ADDR_INPUT_FORMAT_SELECT: begin
                rdata[`FORCE_BIT]               = force_format;
                rdata[`FORCED_HI:`FORCED_LO]    = forced_code;
                rdata[`DETECTED_HI:`DETECTED_LO] = detected_code;
            end
            `ADDR_AMBIGUOUS_CHOICE: begin
                rdata[`AMBIG_HI:0] = ambiguous_choice;
            end
            `ADDR_GENLOCK_MASK_0: begin
                rdata = mask_slice(genlock_mask, 2'h0);
            end
            `ADDR_GENLOCK_MASK_1: begin
                rdata = mask_slice(genlock_mask, 2'h1);
            end
            `ADDR_GENLOCK_MASK_2: begin
                rdata = mask_slice(genlock_mask, 2'h2);
            end
            `ADDR_GENLOCK_MASK_3: begin
                rdata = mask_slice(genlock_mask, 2'h3);
            end
            `ADDR_LOCK_STATUS_FLAGS: begin
                rdata[5:0] = status_flags;
            end
            `ADDR_GENLOCK_CONTROL: begin
                rdata[`CTL_F_MASK:`CTL_H_MASK] = lock_mask;
            end
            default: begin
                rdata = 16'h0000;
            end
        endcase
    end

endmodule // ref_format_genlock_status_regs

//--- ref_format_genlock_status_regs_properties.sv
// Port-level checker for the format and lock register bank.
// Sees only top-level ports; bound from the testbench top file.
`timescale 1ns/1ps
module ref_fmt_props (
    // System
    input wire        clk_sys_i,
    input wire        rst_i,
    // Watched ports
    input wire        cs_n_i,
    input wire        sdout_oe_o,
    input wire        ref_valid_i,
    input wire        field_sync_seen_i,
    input wire        h_locked_i,
    input wire        v_locked_i,
    input wire        f_locked_i,
    input wire        video_pll_locked_i,
    input wire        audio_pll_locked_i,
    input wire [5:0]  video_format_code_o,
    input wire [10:0] ambiguous_choice_o,
    input wire        genlock_permit_o,
    input wire        lock_lost_o,
    input wire        ref_lost_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_ref_lost_pin: assert property (!$past(rst_i) |-> ref_lost_o == !$past(ref_valid_i))
        else $error("ref_lost_o is not the inverse of reference present");
    a_ref_rise_pin: assert property ($rose(ref_valid_i) |=> $fell(ref_lost_o))
        else $error("ref_lost_o did not fall one clock after reference arrived");
    a_lock_needs_clk: assert property (!lock_lost_o && !$past(rst_i)
        |-> $past(video_pll_locked_i && audio_pll_locked_i))
        else $error("lock reported without both clock plls locked");
    a_lock_all_up: assert property (!$past(rst_i) && $past(h_locked_i && v_locked_i
        && (f_locked_i || !field_sync_seen_i) && video_pll_locked_i && audio_pll_locked_i) |-> !lock_lost_o)
        else $error("lock_lost_o high with every lock flag up");
    // Permit and format share one edge, so the current code must be nonzero
    a_permit_code: assert property (genlock_permit_o
        |-> video_format_code_o != 6'h00)
        else $error("genlock permitted for code zero");
    a_oe_idle: assert property (cs_n_i [*5] |-> !sdout_oe_o)
        else $error("sdout driven while deselected");
    a_oe_in_frame: assert property (sdout_oe_o |-> !$past(cs_n_i, 6))
        else $error("sdout driven too long after deselect");
    a_ambig_on_write: assert property ($changed(ambiguous_choice_o) |-> !sdout_oe_o && !$past(sdout_oe_o))
        else $error("ambiguous choice changed outside a write frame");
endmodule // ref_fmt_props

//--- serial_host_model.sv
// Host model for the serial port: one access per frame, MSB first.
// Assumes the bank's system clock; sclk idles low between frames.
`timescale 1ns/1ps
module serial_host_model (
    // System
    input  wire clk_sys_i,
    // Serial pins
    input  wire sdout_i,
    output reg  sclk_o,
    output reg  cs_n_o,
    output reg  sdin_o
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdin_o = 1'b0;
    end

    // Six clocks low and seven high per sclk period keeps clear of the four-clock floor
    task automatic xfer(input bit rd, input logic [11:0] a, input logic [15:0] wd, output logic [15:0] q);
        logic [31:0] s;
        begin
            s = {rd, 3'h0, a, rd ? 16'h0000 : wd};
            @(posedge clk_sys_i);
            cs_n_o <= 1'b0;
            for (int i = 31; i >= 0; i--) begin
                @(posedge clk_sys_i);
                sclk_o <= 1'b0;
                sdin_o <= s[i];
                repeat (6) @(posedge clk_sys_i);
                q = {q[14:0], sdout_i};
                sclk_o <= 1'b1;
                repeat (6) @(posedge clk_sys_i);
            end
            cs_n_o <= 1'b1;
            sclk_o <= 1'b0;
            sdin_o <= ~sdin_o;
            repeat (4) @(posedge clk_sys_i);
        end
    endtask
endmodule // serial_host_model

//--- ref_format_genlock_status_regs_tb.sv
// Self-checking bench for the format and lock register bank.
// Registers reached through the host model; checker bound below.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module ref_format_genlock_status_regs_tb;
    logic        clk_sys_i, rst_i, det_valid_i, ref_valid_i, field_sync_seen_i;
    logic        h_locked_i, v_locked_i, f_locked_i, video_pll_locked_i, audio_pll_locked_i;
    logic [5:0]  det_code_i, c;
    wire         sclk_i, cs_n_i, sdin_i, sdout_o, sdout_oe_o, genlock_permit_o, lock_lost_o, ref_lost_o;
    wire  [5:0]  video_format_code_o;
    wire  [10:0] ambiguous_choice_o;
    logic [15:0] q, m;
    logic [63:0] msk;
    logic        fe, lk;
    int          errors, n_tests;
    logic [5:0]  codes [7] = '{6'd1, 6'd5, 6'd31, 6'd32, 6'd33, 6'd54, 6'd55};

    ref_format_genlock_status_regs uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
        .sdin_i(sdin_i), .sdout_o(sdout_o), .sdout_oe_o(sdout_oe_o), .det_valid_i(det_valid_i),
        .det_code_i(det_code_i), .ref_valid_i(ref_valid_i), .field_sync_seen_i(field_sync_seen_i),
        .h_locked_i(h_locked_i), .v_locked_i(v_locked_i), .f_locked_i(f_locked_i),
        .video_pll_locked_i(video_pll_locked_i), .audio_pll_locked_i(audio_pll_locked_i),
        .video_format_code_o(video_format_code_o), .ambiguous_choice_o(ambiguous_choice_o),
        .genlock_permit_o(genlock_permit_o), .lock_lost_o(lock_lost_o), .ref_lost_o(ref_lost_o));
    serial_host_model host (.clk_sys_i(clk_sys_i), .sdout_i(sdout_o), .sclk_o(sclk_i), .cs_n_o(cs_n_i),
        .sdin_o(sdin_i));

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        host.xfer(1'b0, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        host.xfer(1'b1, a, 16'h0000, q);
        `CHK(q, e)
    endtask
    task automatic summarize();
        if (errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        repeat (90000) @(posedge clk_sys_i);
        errors++;
        summarize();
    end

    initial begin
        {rst_i, det_valid_i, ref_valid_i, field_sync_seen_i, det_code_i} = 10'h200;
        {h_locked_i, v_locked_i, f_locked_i, video_pll_locked_i, audio_pll_locked_i} = 5'h00;
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        `CHK({lock_lost_o, ref_lost_o}, 2'b11)
        for (int i = 15; i <= 22; i++) rd(i[11:0], 16'h0000);
        wr(12'h010, 16'h07ff);
        rd(12'h010, 16'h07ff);
        `CHK(ambiguous_choice_o, 11'h7ff)
        msk = 64'h0040_0001_8000_0020;
        for (int i = 0; i < 4; i++) wr(12'h011 + i[11:0], msk[16*i +: 16]);
        for (int i = 0; i < 4; i++) rd(12'h011 + i[11:0], msk[16*i +: 16]);
        wr(12'h020, 16'h5a5a);
        rd(12'h020, 16'h0000);
        ref_valid_i <= 1'b1;
        det_valid_i <= 1'b1;
        foreach (codes[k]) begin
            det_code_i <= codes[k];
            repeat (3) @(negedge clk_sys_i);
            c = (codes[k] >= 6'd1 && codes[k] <= 6'd54) ? codes[k] : 6'd0;
            `CHK(video_format_code_o, c)
            `CHK(genlock_permit_o, (c != 6'd0) & ~msk[c])
            rd(12'h00f, {10'h000, c});
        end
        // Unrecognised reference, so the host names it by forcing
        det_valid_i <= 1'b0;
        wr(12'h00f, 16'h1abf);
        `CHK(video_format_code_o, 6'h2a)
        `CHK(genlock_permit_o, 1'b1)
        rd(12'h00f, 16'h1a80);
        wr(12'h00f, 16'h0000);
        `CHK(video_format_code_o, 6'h00)
        wr(12'h015, 16'h003f);
        for (int j = 0; j < 192; j++) begin
            if (j % 64 == 0) wr(12'h016, j < 64 ? 16'h0000 : j < 128 ? 16'h001c : 16'h0014);
            if (j == 64) rd(12'h016, 16'h001c);
            m = j < 64 ? 16'h0000 : j < 128 ? 16'h001c : 16'h0014;
            @(posedge clk_sys_i);
            {h_locked_i, v_locked_i, f_locked_i, field_sync_seen_i, video_pll_locked_i, audio_pll_locked_i} <= j[5:0];
            ref_valid_i <= j[0] ^ j[3];
            repeat (3) @(negedge clk_sys_i);
            fe = field_sync_seen_i ? f_locked_i : v_locked_i;
            lk = video_pll_locked_i & audio_pll_locked_i & (fe | m[4]) & (v_locked_i | m[3]) & (h_locked_i | m[2]);
            `CHK({lock_lost_o, ref_lost_o}, {~lk, ~ref_valid_i})
            if (j < 64) rd(12'h015, {10'h000, lk, fe, v_locked_i, h_locked_i,
                video_pll_locked_i & audio_pll_locked_i, ref_valid_i});
        end
        summarize();
    end
endmodule // ref_format_genlock_status_regs_tb

bind ref_format_genlock_status_regs ref_fmt_props chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
    .sdout_oe_o(sdout_oe_o), .ref_valid_i(ref_valid_i), .field_sync_seen_i(field_sync_seen_i),
    .h_locked_i(h_locked_i), .v_locked_i(v_locked_i), .f_locked_i(f_locked_i),
    .video_pll_locked_i(video_pll_locked_i), .audio_pll_locked_i(audio_pll_locked_i),
    .video_format_code_o(video_format_code_o), .ambiguous_choice_o(ambiguous_choice_o),
    .genlock_permit_o(genlock_permit_o), .lock_lost_o(lock_lost_o), .ref_lost_o(ref_lost_o));
